/* File: fault_pkg.sv */
// constants shared by the output fault protection logic
package fault_pkg;

	// ----------------------------------------
	// geometry and reset values
	// ----------------------------------------
	localparam int NUM_CH = 8;
	localparam logic [7:0] STATUS_RST = 8'hff;
	localparam logic [7:0] CMD_RST = 8'hff;
	localparam int SYNC_W = 19;

	// ----------------------------------------
	// timing, clock is 10 MHz
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int BLANK_MIN_US = 70;
	localparam int FDLY_MIN_US = 25;
	localparam int CLIM_MIN_US = 5;
	localparam int BLANK_CYC = (BLANK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FDLY_CYC = (FDLY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLIM_CYC = (CLIM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0] BLANK_LOAD = 10'(BLANK_CYC);
	localparam logic [7:0] FDLY_LOAD = 8'(FDLY_CYC);
	localparam logic [5:0] CLIM_LIMIT = 6'(CLIM_CYC);

	// ----------------------------------------
	// serial framing states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SER_IDLE = 2'h1,
		SER_SHIFT = 2'h2
	} ser_state_e;

endpackage : fault_pkg

/* File: word_if.sv */
// valid/ready word channel between the serial front end, buffer and apply stage
`timescale 1ns/1ns
interface word_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : word_if

/* File: sync2.sv */
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			q <= '0;
		end else if (clk_en) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : sync2

/* File: cmd_buffer.sv */
// two-entry command word buffer with valid/ready on both sides
`timescale 1ns/1ns
module cmd_buffer (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	// channels
	word_if.snk in_w,
	word_if.src out_w
);
	logic [7:0] mem_q [2];
	logic wr_q;
	logic rd_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;

	assign in_w.ready = (cnt_q != 2'h2);
	assign out_w.valid = (cnt_q != 2'h0);
	assign out_w.data = mem_q[rd_q];
	assign push = in_w.valid && in_w.ready;
	assign pop = out_w.valid && out_w.ready;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mem_q[0] <= 8'h00;
			mem_q[1] <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if (clk_en) begin
			if (push) begin
				mem_q[wr_q] <= in_w.data;
				wr_q <= ~wr_q;
			end
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
		end
	end
endmodule : cmd_buffer

/* File: output_fault_protection_logic.sv */
// per-output fault protection, status forming and serial command path
`timescale 1ns/1ns
module output_fault_protection_logic (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	// serial command interface
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// analog indications
	input wire logic [7:0] drain_fault_threshold,
	input wire logic [7:0] over_temp,
	input wire logic load_supply_ov,
	input wire logic logic_supply_uv,
	input wire logic short_fault_shutdown_select,
	// output drives
	output logic [7:0] gate_on,
	output logic [7:0] current_limit
);

	// ----------------------------------------
	// input synchronisation
	// ----------------------------------------
	logic [fault_pkg::SYNC_W-1:0] sync_d;
	logic [fault_pkg::SYNC_W-1:0] sync_q;
	logic [7:0] drain_s;
	logic [7:0] ot_s;
	logic ov_s;
	logic luv_s;
	logic sel_s;

	assign sync_d = {drain_fault_threshold, over_temp, load_supply_ov, logic_supply_uv, short_fault_shutdown_select};

	sync2 #(.W(fault_pkg::SYNC_W)) u_sync (
		.mclk(mclk),
		.resetn(resetn),
		.clk_en(clk_en),
		.d(sync_d),
		.q(sync_q)
	);

	assign drain_s = sync_q[18:11];
	assign ot_s = sync_q[10:3];
	assign ov_s = sync_q[2];
	assign luv_s = sync_q[1];
	assign sel_s = sync_q[0];

	// ----------------------------------------
	// serial front end
	// ----------------------------------------
	fault_pkg::ser_state_e ser_q;
	logic cs_n_q;
	logic sclk_q;
	logic [7:0] sh_q;
	logic so_q;
	logic so_oe_q;
	logic [7:0] status_q;
	logic push_q;
	logic [7:0] push_data_q;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;

	word_if in_w ();
	word_if out_w ();

	assign cs_fall = cs_n_q && !cs_n;
	assign cs_rise = !cs_n_q && cs_n;
	assign sclk_rise = !sclk_q && sclk;
	assign sclk_fall = sclk_q && !sclk;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
		end else if (clk_en) begin
			cs_n_q <= cs_n;
			sclk_q <= sclk;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ser_q <= fault_pkg::SER_IDLE;
		end else if (clk_en) begin
			case (ser_q)
				fault_pkg::SER_IDLE: begin
					if (cs_fall)
						ser_q <= fault_pkg::SER_SHIFT;
				end
				fault_pkg::SER_SHIFT: begin
					if (cs_rise)
						ser_q <= fault_pkg::SER_IDLE;
				end
				default: ser_q <= fault_pkg::SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sh_q <= fault_pkg::STATUS_RST;
			so_q <= 1'b1;
			so_oe_q <= 1'b0;
		end else if (clk_en) begin
			so_oe_q <= !cs_n;
			if (ser_q == fault_pkg::SER_IDLE && cs_fall) begin
				sh_q <= status_q;
				so_q <= status_q[7];
			end else if (ser_q == fault_pkg::SER_SHIFT && !cs_n) begin
				if (sclk_fall)
					sh_q <= {sh_q[6:0], si};
				else if (sclk_rise)
					so_q <= sh_q[7];
			end
		end
	end

	// word held while both buffer entries are still waiting; a later frame end overwrites it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			push_q <= 1'b0;
			push_data_q <= fault_pkg::CMD_RST;
		end else if (clk_en) begin
			if (ser_q == fault_pkg::SER_SHIFT && cs_rise) begin
				push_q <= 1'b1;
				push_data_q <= sh_q;
			end else if (in_w.ready) begin
				push_q <= 1'b0;
			end
		end
	end

	assign in_w.valid = push_q;
	assign in_w.data = push_data_q;

	cmd_buffer u_buf (
		.mclk(mclk),
		.resetn(resetn),
		.clk_en(clk_en),
		.in_w(in_w.snk),
		.out_w(out_w.src)
	);

	// ----------------------------------------
	// command apply stage
	// ----------------------------------------
	logic apply;
	logic [7:0] cmd_on_q;
	logic ov_latch_q;
	logic [7:0] fdly_q;
	logic [7:0] gate_q;
	logic [7:0] climit_q;
	logic [7:0] oc_q;

	// stalls while the logic supply is low; a fourth waiting word overwrites the held one
	assign out_w.ready = !luv_s;
	assign apply = out_w.valid && out_w.ready;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cmd_on_q <= 8'h00;
		end else if (clk_en) begin
			if (luv_s)
				cmd_on_q <= 8'h00;
			else if (apply)
				cmd_on_q <= ~out_w.data;
		end
	end

	// set while present wins over a clearing write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ov_latch_q <= 1'b0;
		end else if (clk_en) begin
			if (ov_s)
				ov_latch_q <= 1'b1;
			else if (apply)
				ov_latch_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fdly_q <= 8'h00;
		end else if (clk_en) begin
			if (apply)
				fdly_q <= fault_pkg::FDLY_LOAD;
			else if (fdly_q != 8'h00)
				fdly_q <= fdly_q - 8'h01;
		end
	end

	// ----------------------------------------
	// per-output protection
	// ----------------------------------------
	for (genvar i = 0; i < fault_pkg::NUM_CH; i++) begin : g_ch
		logic [9:0] blank_q;
		logic [5:0] clim_cnt_q;
		logic short_now;

		// load supply under-voltage has no input at all
		assign short_now = gate_q[i] && drain_s[i];

		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				blank_q <= 10'h000;
			end else if (clk_en) begin
				if (apply && !out_w.data[i])
					blank_q <= fault_pkg::BLANK_LOAD;
				else if (blank_q != 10'h000)
					blank_q <= blank_q - 10'h001;
			end
		end

		// latched short state, one per output
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				oc_q[i] <= 1'b0;
			end else if (clk_en) begin
				if (!sel_s && short_now && blank_q == 10'h000)
					oc_q[i] <= 1'b1;
				else if (apply || sel_s)
					oc_q[i] <= 1'b0;
			end
		end

		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				clim_cnt_q <= 6'h00;
				climit_q[i] <= 1'b0;
			end else if (clk_en) begin
				if (sel_s && short_now) begin
					if (clim_cnt_q != fault_pkg::CLIM_LIMIT)
						clim_cnt_q <= clim_cnt_q + 6'h01;
				end else begin
					clim_cnt_q <= 6'h00;
				end
				climit_q[i] <= sel_s && short_now && clim_cnt_q == fault_pkg::CLIM_LIMIT;
			end
		end

		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				gate_q[i] <= 1'b0;
			end else if (clk_en) begin
				gate_q[i] <= cmd_on_q[i] && !oc_q[i] && !ot_s[i] && !ov_latch_q && !luv_s;
			end
		end

		// high bit means faulted while commanded on, off with the drain high or inside the fault delay, or logic supply low
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				status_q[i] <= fault_pkg::STATUS_RST[i];
			end else if (clk_en) begin
				if (luv_s)
					status_q[i] <= 1'b1;
				else if (cmd_on_q[i])
					status_q[i] <= !gate_q[i] || drain_s[i];
				else if (fdly_q == 8'h00)
					status_q[i] <= drain_s[i];
				else
					status_q[i] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign so = so_q;
	assign so_oe = so_oe_q;
	assign gate_on = gate_q;
	assign current_limit = climit_q;

endmodule : output_fault_protection_logic

/* File: fault_sva.sv */
// assertion checker on the output fault protection ports
`timescale 1ns/1ns
module fault_sva (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	// serial lines
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	// indications
	input wire logic [7:0] drain_fault_threshold,
	input wire logic [7:0] over_temp,
	input wire logic load_supply_ov,
	input wire logic logic_supply_uv,
	input wire logic short_fault_shutdown_select,
	// drives
	input wire logic [7:0] gate_on,
	input wire logic [7:0] current_limit
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ------
	// properties
	// ------
	property p_oe_on; !cs_n [*2] |-> so_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("so_oe low in frame");
	property p_oe_off; cs_n [*2] |-> !so_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("so_oe high when idle");
	property p_so_move;
		$changed(so) |-> ($past(sclk) && !$past(sclk, 2)) || ($past(cs_n, 2) && !$past(cs_n));
	endproperty
	a_so_move: assert property (p_so_move) else $error("so moved off a clock rise");
	property p_ov_off; load_supply_ov [*6] |=> gate_on == 8'h00; endproperty
	a_ov_off: assert property (p_ov_off) else $error("output on in over-voltage");
	property p_uv_off; logic_supply_uv [*6] |=> gate_on == 8'h00; endproperty
	a_uv_off: assert property (p_uv_off) else $error("output on in under-voltage");
	property p_temp_off; $stable(over_temp) [*6] |=> (gate_on & $past(over_temp)) == 8'h00; endproperty
	a_temp_off: assert property (p_temp_off) else $error("hot output still on");
	property p_no_clim; !short_fault_shutdown_select [*8] |=> current_limit == 8'h00; endproperty
	a_no_clim: assert property (p_no_clim) else $error("current limit in shutdown mode");
	// slow start of limiting needs a long-standing cause
	property p_clim_cause;
		(current_limit & ~$past(current_limit) & ~($past(drain_fault_threshold, 8) & $past(gate_on, 8)
			& {8{$past(short_fault_shutdown_select, 8)}})) == 8'h00;
	endproperty
	a_clim_cause: assert property (p_clim_cause) else $error("current limit without cause");
	c_frame: cover property ($fell(cs_n));
	c_clim: cover property (current_limit != 8'h00);
	c_ov: cover property (load_supply_ov && gate_on == 8'h00);
endmodule : fault_sva

bind output_fault_protection_logic fault_sva fault_sva_i (.mclk, .resetn, .clk_en, .cs_n, .sclk, .si, .so, .so_oe,
	.drain_fault_threshold, .over_temp, .load_supply_ov, .logic_supply_uv, .short_fault_shutdown_select,
	.gate_on, .current_limit);

/* File: spi_host.sv */
// host model driving the serial command lines
`timescale 1ns/1ns
module spi_host (
	// clock
	input wire logic mclk,
	// serial lines
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so
);
	initial begin
		cs_n = 1'h1;
		sclk = 1'h0;
		si = 1'h0;
	end
	// one word out, status back, msb first; two cycles a phase
	task automatic xfer(input logic [7:0] cmd, output logic [7:0] sts);
		@(posedge mclk);
		cs_n <= 1'h0;
		repeat (2) @(posedge mclk);
		for (int b = 7; b >= 0; b--) begin
			si <= cmd[b];
			sclk <= 1'h1;
			repeat (2) @(posedge mclk);
			sts[b] = so;
			sclk <= 1'h0;
			repeat (2) @(posedge mclk);
		end
		cs_n <= 1'h1;
		si <= ~si;
		repeat (2) @(posedge mclk);
	endtask : xfer
endmodule : spi_host

/* File: output_fault_protection_logic_test.sv */
// self-checking bench for the output fault protection logic
`timescale 1ns/1ns
module output_fault_protection_logic_test;
	logic mclk = 1'h0;
	logic resetn = 1'h0;
	logic cs_n, sclk, si, so, so_oe;
	logic [7:0] drain_fault_threshold = 8'hff;
	logic [7:0] over_temp = 8'h00;
	logic load_supply_ov = 1'h0;
	logic logic_supply_uv = 1'h0;
	logic short_fault_shutdown_select = 1'h0;
	logic clk_en = 1'h1;
	logic [7:0] gate_on, current_limit, sts;
	logic [7:0] sh = 8'h00;
	logic [7:0] op = 8'h00;
	logic [7:0] cmd = 8'hff;
	logic [7:0] eg = 8'h00;
	logic [31:0] rnd = 32'hcde278cd;
	int errors = 0;
	int checked = 0;

	output_fault_protection_logic output_fault_protection_logic_i (.mclk, .resetn, .clk_en, .cs_n, .sclk,
		.si, .so, .so_oe, .drain_fault_threshold, .over_temp, .load_supply_ov, .logic_supply_uv,
		.short_fault_shutdown_select, .gate_on, .current_limit);
	spi_host spi_host_i (.mclk, .cs_n, .sclk, .si, .so);

	initial forever #50 mclk = ~mclk;
	// load model: off drain pulled high unless open, shorts pull high
	always @(posedge mclk) drain_fault_threshold <= (~gate_on | sh) & ~op;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'h0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr
	function automatic logic [7:0] exp_sts(input logic [7:0] c, input logic [7:0] s, input logic [7:0] o);
		return (~c & s) | (c & ~o);
	endfunction : exp_sts
	function automatic logic [7:0] exp_gate(input logic [7:0] c, input logic [7:0] s, input logic sel);
		return sel ? ~c : ~c & ~s;
	endfunction : exp_gate
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic close_out();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	initial begin
		tick(12);
		resetn <= 1'h1;
		tick(2);
		// random words, shorts and open loads; select low, then high
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			short_fault_shutdown_select <= (i >= 5);
			sh <= rnd[7:0];
			op <= rnd[15:8] & ~rnd[7:0];
			tick(100);
			eg = (i >= 5) ? ~cmd : eg & ~sh;
			chk(gate_on, eg);
			chk(current_limit, (i >= 5) ? ~cmd & sh : 8'h00);
			cmd = rnd[23:16];
			spi_host_i.xfer(cmd, sts);
			tick(6);
			chk(gate_on, ~cmd);
			tick(1000);
			eg = exp_gate(cmd, sh, i >= 5);
			chk(gate_on, eg);
			spi_host_i.xfer(cmd, sts);
			chk(sts, exp_sts(cmd, sh, op));
			tick(6);
			chk(gate_on, ~cmd);
			tick(1000);
			$display("test %0d done", i);
		end
		for (int k = 0; k < 8; k++) begin
			over_temp <= 8'h01 << k;
			tick(10);
			chk(gate_on, eg & ~(8'h01 << k));
			over_temp <= 8'h00;
			tick(10);
			chk(gate_on, eg);
		end
		// frozen enable hides a short hot spell, kept under six cycles
		clk_en <= 1'h0;
		over_temp <= 8'hff;
		tick(4);
		chk(gate_on, eg);
		over_temp <= 8'h00;
		clk_en <= 1'h1;
		tick(10);
		chk(gate_on, eg);
		// open loads on unshorted outputs, then a word inside the fault delay
		op <= ~sh;
		tick(10);
		spi_host_i.xfer(cmd, sts);
		chk(sts, exp_sts(cmd, sh, ~sh));
		tick(20);
		spi_host_i.xfer(cmd, sts);
		chk(sts, exp_sts(cmd, sh, 8'h00));
		tick(1000);
		$display("test freeze and fault delay done");
		load_supply_ov <= 1'h1;
		tick(10);
		chk(gate_on, 8'h00);
		load_supply_ov <= 1'h0;
		tick(100);
		chk(gate_on, 8'h00);
		spi_host_i.xfer(cmd, sts);
		tick(1000);
		chk(gate_on, eg);
		logic_supply_uv <= 1'h1;
		tick(10);
		chk(gate_on, 8'h00);
		spi_host_i.xfer(cmd, sts);
		chk(sts, 8'hff);
		logic_supply_uv <= 1'h0;
		tick(1000);
		chk(gate_on, eg);
		$display("test supply faults done");
		close_out();
	end

	// hang guard, over twice the expected run
	initial begin
		tick(60000);
		errors++;
		close_out();
	end
endmodule : output_fault_protection_logic_test
